// ===== common/gdc_map.svh
/*
 * Constants for the gated decade event counter: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef GDC_MAP_SVH
`define GDC_MAP_SVH

// ==========================================================
// Register offsets (byte addresses)
`define GDC_OFS_CTRL 12'h000
`define GDC_OFS_STAT 12'h004
`define GDC_OFS_CNT_A 12'h008
`define GDC_OFS_CNT_B 12'h00C

// ==========================================================
// Control register fields
`define GDC_CTRL_START 0
`define GDC_CTRL_STOP 1
`define GDC_CTRL_RESET 2
`define GDC_CTRL_MODE_LO 3
`define GDC_CTRL_MODE_HI 4
`define GDC_CTRL_LEADER 5
`define GDC_CTRL_INTTB 6

// ==========================================================
// Status register fields
`define GDC_STAT_RUN 0
`define GDC_STAT_ENABLE 1
`define GDC_STAT_OVF 2
`define GDC_STAT_PRESET 3
`define GDC_STAT_RESET 4

// ==========================================================
// Reset values and decade constants
`define GDC_MODE_RST 2'h0
`define GDC_DEC_MAX 4'h9
`define GDC_DEC_ZERO 4'h0

// ==========================================================
// Timing figures
`define GDC_CLK_HZ 40000000
`define GDC_OVF_PULSE_NS 2000
`define GDC_RST_PULSE_NS 10000
`define GDC_OVF_CYC ((`GDC_OVF_PULSE_NS * (`GDC_CLK_HZ / 1000000)) / 1000)
`define GDC_RST_CYC ((`GDC_RST_PULSE_NS * (`GDC_CLK_HZ / 1000000)) / 1000)

`endif

// ===== common/gdc_pkg.sv
/*
 * Types for the gated decade event counter.
 * Assumes gdc_map.svh is on the include path.
 */
`include "gdc_map.svh"

package gdc_pkg;
    // ==========================================================
    // Counting source mode
    typedef enum logic [1:0] {
        GDC_AUTO_REPEAT = 2'b00,
        GDC_SINGLE_RUN = 2'b01,
        GDC_TEST = 2'b10
    } gdc_mode_t;

    // BCD digit
    typedef logic [3:0] gdc_bcd_t;
endpackage

// ===== core/gdc_decade.sv
/*
 * One BCD decade with enable-in and carry-out.
 * Assumes one clock domain and a synchronous clear.
 */
`timescale 1ns/1ps
`include "gdc_map.svh"

module gdc_decade (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_step,
    output gdc_pkg::gdc_bcd_t o_digit,
    output logic o_carry
);
    import gdc_pkg::*;

    // ==========================================================
    // Digit state
    gdc_bcd_t digit; // Current BCD value
    wire at_max; // Digit sits at nine
    wire gdc_bcd_t next_digit;

    assign at_max = (digit == `GDC_DEC_MAX);
    assign next_digit = at_max ? `GDC_DEC_ZERO : digit + 4'h1;
    assign o_digit = digit;
    // Carry is the step taken while the digit sits at nine, one step pulse
    assign o_carry = i_step & at_max;

    // Advance on each step, clear wins
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            digit <= `GDC_DEC_ZERO;
        end else if (i_clear) begin
            digit <= `GDC_DEC_ZERO;
        end else if (i_step) begin
            digit <= next_digit;
        end
    end

    // Digit never leaves the BCD range
    bcd_range_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        digit <= `GDC_DEC_MAX) else $error("decade out of BCD range");
endmodule

// ===== core/gdc_counter.sv
/*
 * Gated decade event counter channel with APB register slave.
 * Assumes the shaped pulse, reference pulse, gate and shared lines come
 * from pins outside the clock domain; shared lines are open drain.
 */
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "gdc_map.svh"

// Behaviour
// - One count per pulse, rearm on idle
// - Mode picks external or reference pulse
// - Count only when all five qualifiers hold
// - Reset busy low during any reset
// - Idle external gate permits counting
// - Follower low gate line or preset blocks
// - Leader pulls gate line when gated off other than by preset alone
// - Enable and activity lamp track qualifiers
// - First decade steps on falling pulse edge
// - Seven decades chained by carry
// - Reset clears decades and overflow latch
// - Last carry gives two microsecond pulse
// - Overflow latch sticks until reset
// - Positive logic: one is high
// - Start sets, stop clears run flag
// - First preset match drives preset line low
// - General reset pulse ten microseconds wide
// - Each decade readable as BCD

module gdc_counter #(
    parameter int DECADES = 7
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_pulse,
    input wire logic i_ref_pulse,
    input wire logic i_ext_gate,
    input wire logic i_reset_btn,
    input wire logic i_reset_ext,
    input wire logic i_sys_reset,
    input wire logic i_gate_line,
    input wire logic i_preset_line,
    input wire logic i_other_gated_off,
    input wire logic i_preset_match_a,
    input wire logic i_preset_match_b,
    output logic o_gate_line_oe,
    output logic o_preset_line_oe,
    output logic o_enable,
    output logic o_gate_lamp,
    output logic o_overflow,
    output logic o_ovf_lamp,
    output logic o_reset_busy_n,
    output logic [4*DECADES-1:0] o_bcd
);
    import gdc_pkg::*;

    localparam int OVF_CYC = `GDC_OVF_CYC;
    localparam int RST_CYC = `GDC_RST_CYC;

    // ==========================================================
    // Input synchronisers
    logic [1:0] s_pulse, s_ref, s_gate, s_btn, s_ext, s_sys;
    logic [1:0] s_gline, s_pline, s_other, s_pma, s_pmb;

    // Two stages per pin, second stage only is read
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_pulse <= 2'h0;
            s_ref <= 2'h0;
            s_gate <= 2'h3;
            s_btn <= 2'h0;
            s_ext <= 2'h0;
            s_sys <= 2'h0;
            s_gline <= 2'h3;
            s_pline <= 2'h3;
            s_other <= 2'h0;
            s_pma <= 2'h0;
            s_pmb <= 2'h0;
        end else begin
            s_pulse <= {s_pulse[0], i_pulse};
            s_ref <= {s_ref[0], i_ref_pulse};
            s_gate <= {s_gate[0], i_ext_gate};
            s_btn <= {s_btn[0], i_reset_btn};
            s_ext <= {s_ext[0], i_reset_ext};
            s_sys <= {s_sys[0], i_sys_reset};
            s_gline <= {s_gline[0], i_gate_line};
            s_pline <= {s_pline[0], i_preset_line};
            s_other <= {s_other[0], i_other_gated_off};
            s_pma <= {s_pma[0], i_preset_match_a};
            s_pmb <= {s_pmb[0], i_preset_match_b};
        end
    end

    // ==========================================================
    // Control registers
    logic run; // Run state flag
    logic leader; // Leader configuration
    logic int_tb; // Internal time base in use
    gdc_mode_t mode; // Counting source
    logic preset_mem; // Preset memory flag
    logic ovf_latch; // Sticky overflow
    logic [15:0] rst_cnt; // General reset pulse timer
    logic [15:0] ovf_cnt; // Overflow pulse timer
    logic src_q; // Previous selected pulse level
    logic ref_q; // Previous reference level
    logic start_pend, stop_pend; // Run changes waiting for sync

    // APB decode
    wire apb_wr = i_psel & i_penable & i_pwrite;
    wire apb_rd = i_psel & i_penable & ~i_pwrite;
    wire sel_ctrl = (i_paddr == `GDC_OFS_CTRL);
    wire sel_stat = (i_paddr == `GDC_OFS_STAT);
    wire sel_cnta = (i_paddr == `GDC_OFS_CNT_A);
    wire sel_cntb = (i_paddr == `GDC_OFS_CNT_B);
    wire mapped = sel_ctrl | sel_stat | sel_cnta | sel_cntb;
    wire ctrl_wr = apb_wr & sel_ctrl;
    wire sw_start = ctrl_wr & i_pwdata[`GDC_CTRL_START];
    wire sw_stop = ctrl_wr & i_pwdata[`GDC_CTRL_STOP];
    wire sw_reset = ctrl_wr & i_pwdata[`GDC_CTRL_RESET];

    // ==========================================================
    // Reset circuit
    // Reset pulse trigger
    wire rst_src = s_btn[1] | s_ext[1] | s_sys[1] | sw_reset;
    wire rst_active = (rst_cnt != 16'h0);
    wire next_busy_n = ~(rst_src | rst_active);

    // Timer reloads while any source stays active
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_cnt <= 16'h0;
        end else if (rst_src) begin
            rst_cnt <= RST_CYC[15:0];
        end else if (rst_active) begin
            rst_cnt <= rst_cnt - 16'h1;
        end
    end

    // ==========================================================
    // Source select and pulse edge
    // Test mode routes reference
    wire src_lvl = (mode == GDC_TEST) ? s_ref[1] : s_pulse[1];
    wire src_fall = src_q & ~src_lvl;
    wire ref_rise = s_ref[1] & ~ref_q;

    // ==========================================================
    // Gating
    // High external gate permits
    wire ext_ok = s_gate[1];
    wire gline_ok = leader | s_gline[1];
    wire pline_ok = s_pline[1];
    wire next_enable = run & o_reset_busy_n & ext_ok & gline_ok & pline_ok;
    wire own_off = ~(run & o_reset_busy_n & ext_ok);
    wire next_gate_oe = leader & (own_off | s_other[1]);
    wire step0 = o_enable & src_fall;

    // ==========================================================
    // Run flag, preset memory and source history
    // Start and stop, synced to reference if internal base
    wire sync_ok = ~int_tb | ref_rise;
    wire do_start = (sw_start | start_pend) & sync_ok;
    wire do_stop = (sw_stop | stop_pend) & sync_ok;

    // Run flag, stop wins over start
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run <= 1'b0;
            start_pend <= 1'b0;
            stop_pend <= 1'b0;
        end else begin
            run <= do_stop ? 1'b0 : (do_start ? 1'b1 : run);
            start_pend <= (sw_start | start_pend) & ~sync_ok;
            stop_pend <= (sw_stop | stop_pend) & ~sync_ok;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            preset_mem <= 1'b0;
        end else if (s_pma[1] | s_pmb[1]) begin
            preset_mem <= 1'b1;
        end else if (rst_active) begin
            preset_mem <= 1'b0;
        end
    end

    // Pulse history registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            src_q <= 1'b0;
            ref_q <= 1'b0;
        end else begin
            src_q <= src_lvl;
            ref_q <= s_ref[1];
        end
    end

    // ==========================================================
    // Decade chain
    // Ripple chain of decades
    wire [DECADES:0] chain;
    wire [4*DECADES-1:0] bcd;
    assign chain[0] = step0;
    genvar g;
    generate
        for (g = 0; g < DECADES; g = g + 1) begin : g_dec
            gdc_decade u_dec (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_clear(rst_active),
                .i_step(chain[g]),
                .o_digit(bcd[4*g +: 4]),
                .o_carry(chain[g+1])
            );
        end
    endgenerate
    wire last_carry = chain[DECADES];

    // ==========================================================
    // Overflow shaper and latch
    // Two microsecond pulse on last carry
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ovf_cnt <= 16'h0;
        end else if (last_carry) begin
            ovf_cnt <= OVF_CYC[15:0];
        end else if (ovf_cnt != 16'h0) begin
            ovf_cnt <= ovf_cnt - 16'h1;
        end
    end

    // Sticky latch, set wins over reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ovf_latch <= 1'b0;
        end else if (last_carry) begin
            ovf_latch <= 1'b1;
        end else if (rst_active) begin
            ovf_latch <= 1'b0;
        end
    end

    // ==========================================================
    // Control configuration and registered outputs
    wire [31:0] ctrl_rd = {25'h0, int_tb, leader, mode, 3'h0};
    wire [31:0] stat_rd = {27'h0, ~o_reset_busy_n, preset_mem, ovf_latch,
        o_enable, run};
    // Readout image, zero above the top decade so short chains still fit
    wire [63:0] bcd_wide = 64'(bcd);
    wire [31:0] next_rdata = sel_ctrl ? ctrl_rd :
        sel_stat ? stat_rd :
        sel_cnta ? {16'h0, bcd_wide[15:0]} :
        sel_cntb ? {16'h0, bcd_wide[31:16]} : 32'h0;

    // Configuration writes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode <= GDC_AUTO_REPEAT;
            leader <= 1'b0;
            int_tb <= 1'b0;
        end else if (ctrl_wr) begin
            mode <= gdc_mode_t'(
                i_pwdata[`GDC_CTRL_MODE_HI:`GDC_CTRL_MODE_LO]);
            leader <= i_pwdata[`GDC_CTRL_LEADER];
            int_tb <= i_pwdata[`GDC_CTRL_INTTB];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_enable <= 1'b0;
            o_gate_lamp <= 1'b0;
            o_gate_line_oe <= 1'b0;
            o_preset_line_oe <= 1'b0;
            o_reset_busy_n <= 1'b0;
            o_overflow <= 1'b0;
            o_ovf_lamp <= 1'b0;
            o_bcd <= '0;
        end else begin
            o_enable <= next_enable;
            o_gate_lamp <= next_enable;
            o_gate_line_oe <= next_gate_oe;
            o_preset_line_oe <= preset_mem;
            o_reset_busy_n <= next_busy_n;
            o_overflow <= last_carry | (ovf_cnt > 16'h1);
            o_ovf_lamp <= ovf_latch | last_carry;
            o_bcd <= bcd;
        end
    end

    // APB answer: zero wait, error on unmapped
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_prdata <= (i_psel & ~i_penable & ~i_pwrite) ? next_rdata : 32'h0;
            o_pready <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~mapped;
        end
    end

    // ==========================================================
    // Checks
    // Step needs enable
    step_gated_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        step0 |-> o_enable) else $error("step while disabled");
    lamp_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_gate_lamp == o_enable) else $error("lamp mismatch");
    busy_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rst_src |=> !o_reset_busy_n) else $error("busy not low");
    ovf_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ovf_latch && !rst_active |=> ovf_latch) else $error("latch lost");
    ovf_width_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        last_carry |=> o_overflow [*8]) else $error("overflow pulse short");
    rst_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rst_active && !last_carry |=> bcd == '0 && !ovf_latch)
        else $error("reset did not clear");
    lead_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        leader && !run |=> o_gate_line_oe) else $error("gate line free");
    preset_drv_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        preset_mem |=> o_preset_line_oe) else $error("preset line free");
    single_cnt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        step0 |=> !step0) else $error("double count");

    count_c: cover property (@(posedge i_clk) step0);
    ovf_c: cover property (@(posedge i_clk) last_carry);
    test_c: cover property (@(posedge i_clk) mode == GDC_TEST && step0);
endmodule

// ===== bench/gdc_far_side.sv
/*
 * Far side of the counting channel: pulse sources, external gate source
 * and the open-drain shared gate and preset lines with their pull-ups.
 * Assumes the bench calls its tasks right after a rising clock edge.
 */
`timescale 1ns/1ps

module gdc_far_side (
    input wire logic i_clk,
    input wire logic i_gate_oe,
    input wire logic i_preset_oe,
    output logic o_pulse,
    output logic o_ref_pulse,
    output logic o_ext_gate,
    output logic o_gate_line,
    output logic o_preset_line
);
    // ==========================================================
    // Line state
    logic ext_off = 1'b0; // Gate source grounds the gate input
    logic gate_low = 1'b0; // Another unit pulls the gate line
    logic preset_low = 1'b0; // Another unit pulls the preset line

    initial begin
        o_pulse = 1'b0;
        o_ref_pulse = 1'b0;
    end

    assign o_ext_gate = ~ext_off;
    assign o_gate_line = ~(i_gate_oe | gate_low);
    assign o_preset_line = ~(i_preset_oe | preset_low);

    // ==========================================================
    // One pulse, held high for hi cycles, then idle for three
    task automatic send(input logic use_ref, input int hi);
        @(posedge i_clk);
        if (use_ref) begin
            o_ref_pulse <= 1'b1;
        end else begin
            o_pulse <= 1'b1;
        end
        repeat (hi) @(posedge i_clk);
        o_pulse <= 1'b0;
        o_ref_pulse <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask

    // Sets who blocks: gate source, gate line, preset line
    task automatic lines(input logic e, input logic g, input logic p);
        @(posedge i_clk);
        ext_off <= e;
        gate_low <= g;
        preset_low <= p;
    endtask
endmodule

// ===== bench/gdc_counter_tb.sv
/*
 * Self-checking bench for the gated decade event counter channel.
 * Assumes gdc_map.svh on the include path and the far-side model.
 */
`timescale 1ns/1ps
`include "gdc_map.svh"

module gdc_counter_tb;
    import gdc_pkg::*;
    localparam int DEC = 3; // Short chain keeps overflow reachable
    // ==========================================================
    // Stimulus and observation
    logic i_clk = 1'b0, i_rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic btn = 1'b0, rext = 1'b0, sysr = 1'b0, other_off = 1'b0;
    logic pm_a = 1'b0, pm_b = 1'b0, err, pready, pslverr;
    logic pulse, refp, ext_gate, gate_line, preset_line;
    logic gate_oe, preset_oe, enable, lamp, ovf, ovf_lamp, busy_n;
    logic [4*DEC-1:0] bcd;
    int fails = 0, compares = 0, cnt = 0, ovf_w = 0, busy_w = 0, w0;

    always #12.5 i_clk = ~i_clk;

    // Cycle counts of the overflow pulse and of reset activity
    always @(posedge i_clk) begin
        if (ovf === 1'b1) ovf_w <= ovf_w + 1;
        if (busy_n === 1'b0) busy_w <= busy_w + 1;
    end

    gdc_counter #(.DECADES(DEC)) u_gdc_counter (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_pulse(pulse), .i_ref_pulse(refp),
        .i_ext_gate(ext_gate), .i_reset_btn(btn), .i_reset_ext(rext),
        .i_sys_reset(sysr), .i_gate_line(gate_line),
        .i_preset_line(preset_line), .i_other_gated_off(other_off),
        .i_preset_match_a(pm_a), .i_preset_match_b(pm_b),
        .o_gate_line_oe(gate_oe), .o_preset_line_oe(preset_oe),
        .o_enable(enable), .o_gate_lamp(lamp), .o_overflow(ovf),
        .o_ovf_lamp(ovf_lamp), .o_reset_busy_n(busy_n), .o_bcd(bcd));

    gdc_far_side u_gdc_far_side (
        .i_clk(i_clk), .i_gate_oe(gate_oe), .i_preset_oe(preset_oe),
        .o_pulse(pulse), .o_ref_pulse(refp), .o_ext_gate(ext_gate),
        .o_gate_line(gate_line), .o_preset_line(preset_line));

    // ==========================================================
    // Shared tasks
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data and error land in rd and err
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge i_clk);
            if (pready === 1'b1) break;
        end
        if (k == 16) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expected BCD image of a count
    function automatic logic [4*DEC-1:0] to_bcd(input int v);
        to_bcd = {4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction

    // Lets a pulse ripple into the digits, then checks them
    task automatic chk();
        repeat (4) @(posedge i_clk);
        cmp(32'(bcd), 32'(to_bcd(cnt)));
    endtask

    task automatic end_of_test();
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake or counter
    initial begin
        repeat (40000) @(posedge i_clk);
        fails++;
        end_of_test();
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        cmp(busy_n, 1'b1);
        apb(1'b0, `GDC_OFS_STAT, 32'h0);
        cmp(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        cmp({31'h0, err}, 32'h1);
        apb(1'b1, `GDC_OFS_CTRL, 32'h1);
        repeat (5) @(posedge i_clk);
        cmp({lamp, enable}, 2'h3);
        // Short, very long, short pulse: three counts
        u_gdc_far_side.send(1'b0, 2);
        u_gdc_far_side.send(1'b0, 20);
        u_gdc_far_side.send(1'b0, 2);
        cnt = 3;
        chk();
        apb(1'b0, `GDC_OFS_CNT_A, 32'h0);
        cmp(rd, 32'(to_bcd(cnt)));
        // Each far-side qualifier (gate source, gate line, preset line) alone blocks counting
        for (int k = 0; k < 3; k++) begin
            u_gdc_far_side.lines(k == 0, k == 1, k == 2);
            repeat (4) @(posedge i_clk);
            cmp(enable, 1'b0);
            u_gdc_far_side.send(1'b0, 2);
            chk();
            u_gdc_far_side.lines(1'b0, 1'b0, 1'b0);
        end
        apb(1'b1, `GDC_OFS_CTRL, 32'h2);
        u_gdc_far_side.send(1'b0, 2);
        chk();
        apb(1'b0, `GDC_OFS_STAT, 32'h0);
        cmp(rd[0], 1'b0);
        // Leader pulls the gate line unless only preset blocks
        apb(1'b1, `GDC_OFS_CTRL, 32'h21);
        repeat (5) @(posedge i_clk);
        cmp(gate_oe, 1'b0);
        other_off <= 1'b1;
        repeat (4) @(posedge i_clk);
        cmp(gate_oe, 1'b1);
        other_off <= 1'b0;
        u_gdc_far_side.lines(1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge i_clk);
        cmp(gate_oe, 1'b1);
        u_gdc_far_side.lines(1'b0, 1'b0, 1'b1);
        repeat (4) @(posedge i_clk);
        cmp({gate_oe, enable}, 2'h0);
        u_gdc_far_side.lines(1'b0, 1'b0, 1'b0);
        // A stopped leader also holds the gate line down
        apb(1'b1, `GDC_OFS_CTRL, 32'h22);
        repeat (4) @(posedge i_clk);
        cmp(gate_oe, 1'b1);
        // Source selection in every mode
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, `GDC_OFS_CTRL, 32'((m << 3) | 1));
            u_gdc_far_side.send(1'b0, 2);
            cnt += (m != 2) ? 1 : 0;
            chk();
            u_gdc_far_side.send(1'b1, 2);
            cnt += (m == 2) ? 1 : 0;
            chk();
        end
        // Fill all decades, then overflow
        apb(1'b1, `GDC_OFS_CTRL, 32'h1);
        while (cnt < 999) begin
            u_gdc_far_side.send(1'b0, 2);
            cnt++;
        end
        chk();
        cmp(ovf_lamp, 1'b0);
        w0 = ovf_w;
        u_gdc_far_side.send(1'b0, 2);
        cnt = 0;
        repeat (100) @(posedge i_clk);
        cmp(32'(ovf_w - w0 inside {[79:81]}), 32'h1);
        cmp(ovf_lamp, 1'b1);
        u_gdc_far_side.send(1'b0, 2);
        u_gdc_far_side.send(1'b0, 2);
        cnt = 2;
        chk();
        cmp(ovf_lamp, 1'b1);
        // Every reset source clears, blocks counting, lasts its span
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `GDC_OFS_CTRL, 32'h1);
            w0 = busy_w;
            if (s == 3) begin
                apb(1'b1, `GDC_OFS_CTRL, 32'h4);
            end else begin
                btn <= (s == 0);
                rext <= (s == 1);
                sysr <= (s == 2);
                repeat (3) @(posedge i_clk);
                {btn, rext, sysr} <= 3'h0;
            end
            repeat (2) @(posedge i_clk);
            cmp(busy_n, 1'b0);
            u_gdc_far_side.send(1'b0, 2);
            for (int k = 0; k < 600 && busy_n !== 1'b1; k++) begin
                @(posedge i_clk);
            end
            cmp(32'(busy_w - w0 inside {[396:408]}), 32'h1);
            cnt = 0;
            chk();
            cmp(ovf_lamp, 1'b0);
        end
        // First preset match from either side grounds the preset line
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, `GDC_OFS_CTRL, 32'h1);
            pm_a <= (p == 0);
            pm_b <= (p == 1);
            repeat (3) @(posedge i_clk);
            {pm_a, pm_b} <= 2'h0;
            repeat (5) @(posedge i_clk);
            cmp({preset_oe, enable}, 2'h2);
            apb(1'b1, `GDC_OFS_CTRL, 32'h4);
            repeat (420) @(posedge i_clk);
            cmp(preset_oe, 1'b0);
        end
        // With the internal time base, start waits for a reference pulse
        apb(1'b1, `GDC_OFS_CTRL, 32'h42);
        apb(1'b1, `GDC_OFS_CTRL, 32'h41);
        repeat (10) @(posedge i_clk);
        apb(1'b0, `GDC_OFS_STAT, 32'h0);
        cmp(rd[0], 1'b0);
        u_gdc_far_side.send(1'b1, 2);
        apb(1'b0, `GDC_OFS_STAT, 32'h0);
        cmp(rd[0], 1'b1);
        end_of_test();
    end
endmodule
